// File: logic/csm_consts.svh
// Purpose: Constants for the processing-state and mode-select block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH
`define CSM_MODE_W 3
`define CSM_MODE4 3'h4
`define CSM_MODE5 3'h5
`define CSM_MODE6 3'h6
`define CSM_MODE7 3'h7
`define CSM_MODE_RST 3'h7
`define CSM_VEC_W 8
`define CSM_VEC_RESET 8'h00
`define CSM_VEC_TRACE 8'h05
`define CSM_VEC_TRAP 8'h08
`define CSM_AREA_W 8
`define CSM_AREA_RST 8'hff
`endif

// File: logic/csm_pkg.sv
// Purpose: Types for the processing-state and mode-select block
// Assumes: Nothing
// Notes: State codes written out
package csm_pkg;
    typedef enum logic [2:0] {
        CSM_RESET = 3'h0,
        CSM_EXCEPT = 3'h1,
        CSM_EXEC = 3'h2,
        CSM_BUSREL = 3'h3,
        CSM_PDOWN = 3'h4
    } csm_state_t;
    typedef enum logic [1:0] {
        CSM_SRC_RESET = 2'h0,
        CSM_SRC_TRACE = 2'h1,
        CSM_SRC_IRQ = 2'h2,
        CSM_SRC_TRAP = 2'h3
    } csm_src_t;
endpackage : csm_pkg

// File: logic/csm_mode_dec.sv
// Purpose: Decode of latched mode straps
// Assumes: Straps already latched
// Notes: Patterns below 100 are not valid modes and fall back to single-chip
`timescale 1ns/1ps
`include "csm_consts.svh"
module csm_mode_dec
(
    input wire logic [2:0] mode_bits,
    output logic mode_valid,
    output logic rom_en,
    output logic ext_space,
    output logic init_bus16
);
    import csm_pkg::*;
    always_comb
    begin
        mode_valid = 1'b1;
        rom_en = 1'b1;
        ext_space = 1'b0;
        init_bus16 = 1'b0;
        case (mode_bits)
            `CSM_MODE4:
            begin
                rom_en = 1'b0;
                ext_space = 1'b1;
                init_bus16 = 1'b1;
            end
            `CSM_MODE5:
            begin
                rom_en = 1'b0;
                ext_space = 1'b1;
            end
            `CSM_MODE6:
            begin
                ext_space = 1'b1;
            end
            `CSM_MODE7:
            begin
                ext_space = 1'b0;
            end
            default:
            begin
                mode_valid = 1'b0;
            end
        endcase
    end
endmodule : csm_mode_dec

// File: logic/csm_ctrl.sv
// Purpose: Top-level processing states and operating mode selection
// Assumes: All inputs synchronous to core_clk; area widths from bus controller
// Notes: Vector fetch is a one-cycle request; core answers with vec_done
`timescale 1ns/1ps
`include "csm_consts.svh"
// Functional notes
// - Reset pin low halts and initialises everything
// - All interrupts masked during reset
// - Reset exception starts on pin rising
// - Watchdog overflow gives same reset state
// - Every exception fetches vector and branches
// - Release bus to other master, halt CPU
// - Sleep or standby enters power-down state
// - Four modes, 4 to 7, from straps
// - Strap patterns decode ROM and bus width
// - Modes 4 to 6 allow external space
// - Area widths set by bus controller later
// - Any 16-bit area gives 16-bit bus
// - Mode 7 has no external space
module csm_ctrl
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic reset_pin_n,
    input wire logic wdt_ovf,
    input wire logic mode_strap_bit2,
    input wire logic mode_strap_bit1,
    input wire logic mode_strap_bit0,
    input wire logic exc_req,
    input wire csm_pkg::csm_src_t exc_src,
    input wire logic [7:0] irq_vec,
    input wire logic vec_done,
    input wire logic bus_req,
    input wire logic sleep_exec,
    input wire logic hw_standby,
    input wire logic wake_req,
    input wire logic area_cfg_we,
    input wire logic [7:0] area_cfg_wide,
    output csm_pkg::csm_state_t cpu_state,
    output logic cpu_run,
    output logic periph_rst,
    output logic irq_mask_all,
    output logic vec_fetch,
    output logic [7:0] vec_num,
    output logic bus_grant,
    output logic [2:0] op_mode,
    output logic mode_valid,
    output logic rom_en,
    output logic ext_space,
    output logic bus16
);
    import csm_pkg::*;

    csm_state_t state_q;
    logic rst_hold_q;
    logic pin_prev_q;
    logic [2:0] mode_q;
    logic [7:0] area_wide_q;
    logic dec_valid;
    logic dec_rom;
    logic dec_ext;
    logic dec_bus16;
    logic in_reset;
    logic pin_rise;

    function automatic logic [7:0] vec_of(input csm_src_t src, input logic [7:0] iv);
        case (src)
            CSM_SRC_RESET: vec_of = `CSM_VEC_RESET;
            CSM_SRC_TRACE: vec_of = `CSM_VEC_TRACE;
            CSM_SRC_TRAP: vec_of = `CSM_VEC_TRAP;
            default: vec_of = iv;
        endcase
    endfunction : vec_of

    // Watchdog overflow feeds the same path as the pin
    assign in_reset = !reset_pin_n || wdt_ovf;
    assign pin_rise = reset_pin_n && !pin_prev_q;

    csm_mode_dec u_dec
    (
        .mode_bits(mode_q),
        .mode_valid(dec_valid),
        .rom_en(dec_rom),
        .ext_space(dec_ext),
        .init_bus16(dec_bus16)
    );

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            pin_prev_q <= 1'b0;
        else if (clk_en)
            pin_prev_q <= reset_pin_n;
    end

    // Watchdog reset has no pin edge, so a hold flag waits for its release
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            rst_hold_q <= 1'b1;
        else if (clk_en)
            rst_hold_q <= in_reset || (rst_hold_q && !reset_pin_n);
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state_q <= CSM_RESET;
            vec_fetch <= 1'b0;
            vec_num <= `CSM_VEC_RESET;
        end
        else if (clk_en)
        begin
            vec_fetch <= 1'b0;
            if (in_reset)
                state_q <= CSM_RESET;
            else
            begin
                case (state_q)
                    CSM_RESET:
                    begin
                        if (rst_hold_q && (pin_rise || reset_pin_n))
                        begin
                            state_q <= CSM_EXCEPT;
                            vec_fetch <= 1'b1;
                            vec_num <= `CSM_VEC_RESET;
                        end
                    end
                    CSM_EXCEPT:
                    begin
                        if (vec_done)
                            state_q <= CSM_EXEC;
                    end
                    CSM_EXEC:
                    begin
                        if (bus_req)
                            state_q <= CSM_BUSREL;
                        else if (hw_standby || sleep_exec)
                            state_q <= CSM_PDOWN;
                        else if (exc_req)
                        begin
                            state_q <= CSM_EXCEPT;
                            vec_fetch <= 1'b1;
                            vec_num <= vec_of(exc_src, irq_vec);
                        end
                    end
                    CSM_BUSREL:
                    begin
                        if (!bus_req)
                            state_q <= CSM_EXEC;
                    end
                    CSM_PDOWN:
                    begin
                        // While hw_standby is held, only reset leaves; once it drops, wake_req returns to CSM_EXEC
                        if (wake_req && !hw_standby)
                            state_q <= CSM_EXEC;
                    end
                    default:
                        state_q <= CSM_RESET;
                endcase
            end
        end
    end

    // Straps sampled only in reset; later changes are ignored by design
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            mode_q <= `CSM_MODE_RST;
        else if (clk_en && in_reset)
            mode_q <= {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0};
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            area_wide_q <= `CSM_AREA_RST;
        else if (clk_en)
        begin
            if (in_reset)
                area_wide_q <= dec_bus16 ? `CSM_AREA_RST : {`CSM_AREA_W{1'b0}};
            else if (area_cfg_we && state_q != CSM_RESET)
                area_wide_q <= area_cfg_wide;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cpu_state <= CSM_RESET;
            cpu_run <= 1'b0;
            periph_rst <= 1'b1;
            irq_mask_all <= 1'b1;
            bus_grant <= 1'b0;
            op_mode <= `CSM_MODE_RST;
            mode_valid <= 1'b1;
            rom_en <= 1'b1;
            ext_space <= 1'b0;
            bus16 <= 1'b0;
        end
        else if (clk_en)
        begin
            cpu_state <= state_q;
            cpu_run <= state_q == CSM_EXEC || state_q == CSM_EXCEPT;
            periph_rst <= state_q == CSM_RESET;
            irq_mask_all <= state_q == CSM_RESET;
            bus_grant <= state_q == CSM_BUSREL;
            op_mode <= mode_q;
            mode_valid <= dec_valid;
            rom_en <= dec_rom;
            ext_space <= dec_ext;
            bus16 <= dec_ext && (|area_wide_q);
        end
    end

    property p_reset_hold;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && in_reset) |=> state_q == CSM_RESET;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset did not hold state");

    property p_mask;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && state_q == CSM_RESET) |=> irq_mask_all;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupts not masked in reset");

    property p_no_exc_low;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && !reset_pin_n) |=> !vec_fetch;
    endproperty
    a_no_exc_low: assert property (p_no_exc_low) else $error("exception began while pin low");

    property p_wdt;
        @(posedge core_clk) disable iff (!nrst)
        // Second enable needed, otherwise the output stage is frozen one cycle
        (clk_en && wdt_ovf) ##1 clk_en |-> state_q == CSM_RESET ##1 periph_rst;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog did not reset");

    property p_vec;
        @(posedge core_clk) disable iff (!nrst)
        vec_fetch |-> state_q == CSM_EXCEPT;
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch outside exception state");

    property p_busrel;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && state_q == CSM_BUSREL) |=> !cpu_run && bus_grant;
    endproperty
    a_busrel: assert property (p_busrel) else $error("bus not released or cpu running");

    property p_sleep;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && state_q == CSM_EXEC && sleep_exec && !bus_req && !in_reset) |=> state_q == CSM_PDOWN;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not power down");

    property p_mode7;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && mode_q == `CSM_MODE7) |=> !ext_space && !bus16;
    endproperty
    a_mode7: assert property (p_mode7) else $error("external space in mode 7");

    property p_mode_stable;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && !in_reset) |=> $stable(mode_q);
    endproperty
    a_mode_stable: assert property (p_mode_stable) else $error("mode changed while running");
endmodule : csm_ctrl

// File: bench/csm_board.sv
// Purpose: Board straps, reset button and second bus master facing the block
// Assumes: Bench commands arrive synchronous to core_clk
// Notes: Straps only move when the bench commands it
`timescale 1ns/1ps
module csm_board
(
    input wire logic core_clk,
    input wire logic [2:0] strap_sel,
    input wire logic hold_rst,
    input wire logic want_bus,
    output logic reset_pin_n,
    output logic mode_strap_bit2,
    output logic mode_strap_bit1,
    output logic mode_strap_bit0,
    output logic bus_req
);
    initial
    begin
        reset_pin_n = 1'b0;
        {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0} = 3'h7;
        bus_req = 1'b0;
    end
    always @(posedge core_clk)
    begin
        reset_pin_n <= !hold_rst;
        {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0} <= strap_sel;
        // Request held for the whole transfer, never dropped early
        bus_req <= want_bus;
    end
endmodule : csm_board

// File: bench/cpu_state_and_mode_select_test.sv
// Purpose: Self-checking bench for the processing-state and mode-select block
// Assumes: Outputs registered, sampled 1 ns after the edge
// Notes: Every wait is bounded
`timescale 1ns/1ps
module cpu_state_and_mode_select_test;
    import csm_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, wdt_ovf = 1'b0, exc_req = 1'b0, vec_done = 1'b0;
    logic sleep_exec = 1'b0, hw_standby = 1'b0, wake_req = 1'b0, area_cfg_we = 1'b0, hold_rst = 1'b1;
    logic want_bus = 1'b0, reset_pin_n, mode_strap_bit2, mode_strap_bit1, mode_strap_bit0, bus_req;
    logic [2:0] strap_sel = 3'h7;
    logic [7:0] irq_vec = 8'h5a, area_cfg_wide = 8'h00, vec_num;
    csm_src_t exc_src = CSM_SRC_TRACE;
    csm_state_t cpu_state;
    logic cpu_run, periph_rst, irq_mask_all, vec_fetch, bus_grant, mode_valid, rom_en, ext_space, bus16;
    logic [2:0] op_mode;
    int fails = 0, num_checks = 0;
    // Pattern 2 is not a valid mode; mode 5 must come last for the strap check
    logic [2:0] ml [5] = '{3'h4, 3'h7, 3'h6, 3'h2, 3'h5};
    always #10 core_clk = ~core_clk;
    csm_board brd_u (.core_clk(core_clk), .strap_sel(strap_sel), .hold_rst(hold_rst), .want_bus(want_bus),
        .reset_pin_n(reset_pin_n), .mode_strap_bit2(mode_strap_bit2), .mode_strap_bit1(mode_strap_bit1),
        .mode_strap_bit0(mode_strap_bit0), .bus_req(bus_req));
    csm_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
        .wdt_ovf(wdt_ovf), .mode_strap_bit2(mode_strap_bit2), .mode_strap_bit1(mode_strap_bit1),
        .mode_strap_bit0(mode_strap_bit0), .exc_req(exc_req), .exc_src(exc_src), .irq_vec(irq_vec),
        .vec_done(vec_done), .bus_req(bus_req), .sleep_exec(sleep_exec), .hw_standby(hw_standby),
        .wake_req(wake_req), .area_cfg_we(area_cfg_we), .area_cfg_wide(area_cfg_wide), .cpu_state(cpu_state),
        .cpu_run(cpu_run), .periph_rst(periph_rst), .irq_mask_all(irq_mask_all), .vec_fetch(vec_fetch),
        .vec_num(vec_num), .bus_grant(bus_grant), .op_mode(op_mode), .mode_valid(mode_valid),
        .rom_en(rom_en), .ext_space(ext_space), .bus16(bus16));
    task automatic end_sim();
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wait_state(input csm_state_t s);
        // Step off the edge so the outputs are settled when first looked at
        #1;
        for (int i = 0; i < 40 && cpu_state !== s; i++) tick(1);
        chk(cpu_state, s);
        if (cpu_state !== s) end_sim();
    endtask : wait_state
    task automatic wait_vec(input logic [7:0] exp);
        #1;
        for (int i = 0; i < 20 && vec_fetch !== 1'b1; i++) tick(1);
        chk({vec_fetch, vec_num}, {1'b1, exp});
        if (vec_fetch !== 1'b1) end_sim();
        @(posedge core_clk);
        vec_done <= 1'b1;
        @(posedge core_clk);
        vec_done <= 1'b0;
        wait_state(CSM_EXEC);
    endtask : wait_vec
    task automatic run_mode(input logic [2:0] m);
        @(posedge core_clk);
        strap_sel <= m;
        hold_rst <= 1'b1;
        tick(5);
        chk({cpu_state, periph_rst, cpu_run, vec_fetch}, 6'h04);
        chk(irq_mask_all, 1'b1);
        @(posedge core_clk);
        hold_rst <= 1'b0;
        wait_vec(8'h00);
        chk({irq_mask_all, periph_rst, cpu_run}, 3'h1);
        chk(op_mode, m);
        chk(mode_valid, m[2]);
        chk({rom_en, bus16}, {m[1] || !m[2], m == 3'h4});
        chk(ext_space, m[2] && m != 3'h7);
    endtask : run_mode
    task automatic do_exc(input csm_src_t s, input logic [7:0] exp);
        @(posedge core_clk);
        exc_src <= s;
        exc_req <= 1'b1;
        @(posedge core_clk);
        exc_req <= 1'b0;
        wait_vec(exp);
    endtask : do_exc
    task automatic wr_area(input logic [7:0] v, input logic exp);
        @(posedge core_clk);
        area_cfg_wide <= v;
        area_cfg_we <= 1'b1;
        @(posedge core_clk);
        area_cfg_we <= 1'b0;
        tick(3);
        chk(bus16, exp);
    endtask : wr_area
    task automatic do_power();
        @(posedge core_clk);
        sleep_exec <= 1'b1;
        @(posedge core_clk);
        sleep_exec <= 1'b0;
        wait_state(CSM_PDOWN);
        chk(cpu_run, 1'b0);
        @(posedge core_clk);
        wake_req <= 1'b1;
        @(posedge core_clk);
        wake_req <= 1'b0;
        wait_state(CSM_EXEC);
        @(posedge core_clk);
        hw_standby <= 1'b1;
        wait_state(CSM_PDOWN);
        // While hw_standby is held, standby only leaves through a reset, here the watchdog
        @(posedge core_clk);
        wdt_ovf <= 1'b1;
        hw_standby <= 1'b0;
        wait_state(CSM_RESET);
        chk({periph_rst, irq_mask_all, cpu_run}, 3'h6);
        @(posedge core_clk);
        wdt_ovf <= 1'b0;
        wait_vec(8'h00);
    endtask : do_power
    // A request held through a frozen clock must only be taken once enabled
    task automatic do_freeze();
        @(posedge core_clk);
        clk_en <= 1'b0;
        exc_src <= CSM_SRC_TRAP;
        exc_req <= 1'b1;
        tick(3);
        chk({cpu_state, vec_fetch, cpu_run}, {CSM_EXEC, 1'b0, 1'b1});
        @(posedge core_clk);
        clk_en <= 1'b1;
        @(posedge core_clk);
        exc_req <= 1'b0;
        wait_vec(8'h08);
    endtask : do_freeze
    task automatic do_bus();
        @(posedge core_clk);
        want_bus <= 1'b1;
        wait_state(CSM_BUSREL);
        chk({bus_grant, cpu_run}, 2'h2);
        @(posedge core_clk);
        want_bus <= 1'b0;
        wait_state(CSM_EXEC);
        chk({bus_grant, cpu_run}, 2'h1);
    endtask : do_bus
    task automatic do_strap();
        @(posedge core_clk);
        strap_sel <= 3'h4;
        tick(4);
        chk(op_mode, 3'h5);
    endtask : do_strap
    initial
    begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        foreach (ml[i]) run_mode(ml[i]);
        do_exc(CSM_SRC_TRACE, 8'h05);
        do_exc(CSM_SRC_TRAP, 8'h08);
        do_exc(CSM_SRC_IRQ, irq_vec);
        do_freeze();
        do_bus();
        do_strap();
        wr_area(8'h10, 1'b1);
        wr_area(8'h00, 1'b0);
        do_power();
        end_sim();
    end
endmodule : cpu_state_and_mode_select_test
